// *** fsb_snoop_defines.svh ***
// named constants for the front-side bus snoop and request controller
// assumes it is included by the package and by every design file
`ifndef FSB_SNOOP_DEFINES_SVH
`define FSB_SNOOP_DEFINES_SVH

// ****************************************
// bus widths
// ****************************************
`define CMD_W 5
`define DATA_W 64
`define GROUP_W 16
`define GROUPS 4
`define CNT_W 3

// ****************************************
// command decode and data phase
// ****************************************
`define CMD_WRITE_BIT 1
`define XFERS_PER_CLK 3'h4
`define GROUPS_ALL 4'hf

`endif

// *** fsb_snoop_pkg.sv ***
// types shared by the snoop controller and its data lane capture
// assumes the defines header is on the include path
`include "fsb_snoop_defines.svh"

package fsb_snoop_pkg;

	// ****************************************
	// request sequencing
	// ****************************************
	typedef enum logic [2:0] {PH_IDLE, PH_REQ_B, PH_SNOOP, PH_ISSUE, PH_TRDY, PH_DATA} phase_e;

	// ****************************************
	// controller state
	// ****************************************
	typedef struct packed {
		logic clk_s1;
		logic clk_s2;
		logic clk_prev;
		logic ads_s1;
		logic ads_s2;
		logic lock_s1;
		logic lock_s2;
		logic hint_s1;
		logic hint_s2;
		logic hit_s1;
		logic hit_s2;
		logic hitm_s1;
		logic hitm_s2;
		logic [`CMD_W-1:0] cmd_s1;
		logic [`CMD_W-1:0] cmd_s2;
		phase_e phase;
		logic [`CMD_W-1:0] cmd_a;
		logic [`CMD_W-1:0] cmd_b;
		logic hint_cap;
		logic is_write;
		logic atomic;
		logic trdy_n;
		logic req_valid;
		logic auto_pc;
		logic snoop_mod;
		logic snoop_stall;
		logic io_block;
		logic io_grant;
		logic [`CNT_W-1:0] xfer_cnt;
	} ctrl_s;

	// ****************************************
	// lane capture state
	// ****************************************
	typedef struct packed {
		logic [`DATA_W-1:0] d_s1;
		logic [`DATA_W-1:0] d_s2;
		logic [`GROUPS-1:0] inv_s1;
		logic [`GROUPS-1:0] inv_s2;
		logic [`GROUPS-1:0] sp_s1;
		logic [`GROUPS-1:0] sp_s2;
		logic [`GROUPS-1:0] sp_prev;
		logic [`GROUPS-1:0] sn_s1;
		logic [`GROUPS-1:0] sn_s2;
		logic [`GROUPS-1:0] sn_prev;
		logic [`DATA_W-1:0] grp;
		logic [`GROUPS-1:0] seen;
		logic [`DATA_W-1:0] word;
		logic word_valid;
	} lane_s;

endpackage

// *** fsb_lane_if.sv ***
// carrier between the controller and its data lane capture
// pins arrive raw; the lane side synchronises them itself
`timescale 1ns/10ps
`include "fsb_snoop_defines.svh"

interface fsb_lane_if;
	logic [`DATA_W-1:0] data_n;
	logic [`GROUPS-1:0] inv_n;
	logic [`GROUPS-1:0] stb_pos_n;
	logic [`GROUPS-1:0] stb_neg_n;
	logic [`DATA_W-1:0] word;
	logic word_valid;

	modport ctrl (output data_n, output inv_n, output stb_pos_n, output stb_neg_n,
		input word, input word_valid);
	modport lane (input data_n, input inv_n, input stb_pos_n, input stb_neg_n,
		output word, output word_valid);
endinterface

// *** fsb_lane_capture.sv ***
// data lane capture: syncs the host data pins, catches each group on its strobe
// assumes strobes toggle no faster than every two reference clocks
`timescale 1ns/10ps
`include "fsb_snoop_defines.svh"

module fsb_lane_capture (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// lanes
	fsb_lane_if.lane lif
);

	fsb_snoop_pkg::lane_s r_reg;
	fsb_snoop_pkg::lane_s r_next;
	logic [`GROUPS-1:0] edge_hit;

	// wire value back to true value for one group
	function automatic logic [`GROUP_W-1:0] restore(input logic [`GROUP_W-1:0] d_n,
		input logic inv_n);
		logic [`GROUP_W-1:0] t;
		t = ~d_n;
		// an asserted inversion bit means the group travelled inverted
		return inv_n ? t : ~t;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		r_next = r_reg;
		r_next.d_s1 = lif.data_n;
		r_next.d_s2 = r_reg.d_s1;
		r_next.inv_s1 = lif.inv_n;
		r_next.inv_s2 = r_reg.inv_s1;
		r_next.sp_s1 = lif.stb_pos_n;
		r_next.sp_s2 = r_reg.sp_s1;
		r_next.sp_prev = r_reg.sp_s2;
		r_next.sn_s1 = lif.stb_neg_n;
		r_next.sn_s2 = r_reg.sn_s1;
		r_next.sn_prev = r_reg.sn_s2;
		r_next.word_valid = 1'b0;
		edge_hit = (r_reg.sp_prev & ~r_reg.sp_s2) | (r_reg.sn_prev & ~r_reg.sn_s2);
		for (int g = 0; g < `GROUPS; g++)
		begin
			if (edge_hit[g])
			begin
				r_next.grp[g*`GROUP_W +: `GROUP_W] =
					restore(r_reg.d_s2[g*`GROUP_W +: `GROUP_W], r_reg.inv_s2[g]);
			end
		end
		r_next.seen = r_reg.seen | edge_hit;
		// a word is whole once every group has been strobed
		if (r_next.seen == `GROUPS_ALL)
		begin
			r_next.word = r_next.grp;
			r_next.word_valid = 1'b1;
			r_next.seen = '0;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			r_reg <= '0;
		else if (ce)
			r_reg <= r_next;
	end

	assign lif.word = r_reg.word;
	assign lif.word_valid = r_reg.word_valid;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_LANE_RESTORE: assert property (
		ce && r_reg.sp_prev[0] && !r_reg.sp_s2[0]
		|=> r_reg.grp[`GROUP_W-1:0] == ($past(r_reg.inv_s2[0]) ?
		~$past(r_reg.d_s2[`GROUP_W-1:0]) : $past(r_reg.d_s2[`GROUP_W-1:0])))
		else $error("group 0 not restored on its strobe");

endmodule // fsb_lane_capture

// *** fsb_snoop_ctrl.sv ***
// front-side bus snoop, lock and request controller on the memory side
// assumes all bus pins are asynchronous to ref_clk and the bus clock is slow
`timescale 1ns/10ps
`include "fsb_snoop_defines.svh"

module fsb_snoop_ctrl (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// bus clock and request phase pins
	input wire logic bus_clk,
	input wire logic addr_strobe_n,
	input wire logic [`CMD_W-1:0] request_command_n,
	input wire logic page_close_hint_n,
	input wire logic bus_lock_n,
	// snoop result pins
	input wire logic snoop_hit_n,
	input wire logic snoop_hit_modified_n,
	// data pins
	input wire logic [`DATA_W-1:0] host_data_n,
	input wire logic [`GROUPS-1:0] data_invert_n,
	input wire logic [`GROUPS-1:0] data_strobe_pos_n,
	input wire logic [`GROUPS-1:0] data_strobe_neg_n,
	// target ready pin
	output logic target_ready_n,
	// memory scheduler side
	output logic req_valid,
	output logic [`CMD_W-1:0] req_type_a,
	output logic [`CMD_W-1:0] req_type_b,
	output logic req_is_write,
	output logic req_auto_precharge,
	input wire logic req_ready,
	input wire logic wr_buf_ready,
	output logic [`DATA_W-1:0] wr_word,
	output logic wr_word_valid,
	// snoop and lock status
	output logic snoop_modified,
	output logic snoop_stall,
	output logic atomic_active,
	// link and PCIe access gate
	input wire logic io_dram_req,
	output logic io_dram_grant,
	output logic io_dram_block
);

	fsb_snoop_pkg::ctrl_s r_reg;
	fsb_snoop_pkg::ctrl_s r_next;
	logic bus_rise;
	logic bus_fall;

	fsb_lane_if lif ();

	// ****************************************
	// data lanes
	// ****************************************
	assign lif.data_n = host_data_n;
	assign lif.inv_n = data_invert_n;
	assign lif.stb_pos_n = data_strobe_pos_n;
	assign lif.stb_neg_n = data_strobe_neg_n;

	fsb_lane_capture fsb_lane_capture_inst (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.lif(lif)
	);

	// bus clock edges seen after the synchroniser
	assign bus_rise = r_reg.clk_s2 & ~r_reg.clk_prev;
	assign bus_fall = ~r_reg.clk_s2 & r_reg.clk_prev;

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		r_next = r_reg;
		// two-flop synchronisers; stage one feeds stage two only
		r_next.clk_s1 = bus_clk;
		r_next.clk_s2 = r_reg.clk_s1;
		r_next.clk_prev = r_reg.clk_s2;
		r_next.ads_s1 = addr_strobe_n;
		r_next.ads_s2 = r_reg.ads_s1;
		r_next.lock_s1 = bus_lock_n;
		r_next.lock_s2 = r_reg.lock_s1;
		r_next.hint_s1 = page_close_hint_n;
		r_next.hint_s2 = r_reg.hint_s1;
		r_next.hit_s1 = snoop_hit_n;
		r_next.hit_s2 = r_reg.hit_s1;
		r_next.hitm_s1 = snoop_hit_modified_n;
		r_next.hitm_s2 = r_reg.hitm_s1;
		r_next.cmd_s1 = request_command_n;
		r_next.cmd_s2 = r_reg.cmd_s1;

		if (bus_rise)
		begin
			if (!r_reg.ads_s2 && !r_reg.lock_s2)
				r_next.atomic = 1'b1;
			else if (r_reg.lock_s2)
				r_next.atomic = 1'b0;
		end

		r_next.io_block = !r_reg.lock_s2 || r_next.atomic;
		r_next.io_grant = io_dram_req && !r_next.io_block;

		case (r_reg.phase)
			fsb_snoop_pkg::PH_IDLE:
			begin
				if (bus_rise && !r_reg.ads_s2)
				begin
					r_next.cmd_a = ~r_reg.cmd_s2;
					r_next.hint_cap = !r_reg.hint_s2;
					r_next.is_write = ~r_reg.cmd_s2[`CMD_WRITE_BIT];
					r_next.snoop_mod = 1'b0;
					r_next.phase = fsb_snoop_pkg::PH_REQ_B;
				end
			end
			fsb_snoop_pkg::PH_REQ_B:
			begin
				// second half on the falling edge
				if (bus_fall)
				begin
					r_next.cmd_b = ~r_reg.cmd_s2;
					r_next.phase = fsb_snoop_pkg::PH_SNOOP;
				end
			end
			fsb_snoop_pkg::PH_SNOOP:
			begin
				if (bus_rise)
				begin
					r_next.snoop_stall = 1'b0;
					// both hits mean stall, not a result
					if (!r_reg.hit_s2 && !r_reg.hitm_s2)
						r_next.snoop_stall = 1'b1;
					else
					begin
						// modified line comes from the agent
						if (!r_reg.hitm_s2)
						begin
							r_next.snoop_mod = 1'b1;
							r_next.is_write = 1'b1;
						end
						r_next.phase = fsb_snoop_pkg::PH_ISSUE;
					end
				end
			end
			fsb_snoop_pkg::PH_ISSUE:
			begin
				r_next.req_valid = 1'b1;
				r_next.auto_pc = r_reg.hint_cap && !r_reg.is_write;
				if (r_reg.req_valid && req_ready)
				begin
					r_next.req_valid = 1'b0;
					r_next.phase = r_reg.is_write ? fsb_snoop_pkg::PH_TRDY :
						fsb_snoop_pkg::PH_IDLE;
				end
			end
			fsb_snoop_pkg::PH_TRDY:
			begin
				if (r_reg.trdy_n && wr_buf_ready)
					r_next.trdy_n = 1'b0;
				else if (!r_reg.trdy_n && bus_rise)
				begin
					// held until the next bus clock rise, then the data phase runs
					r_next.trdy_n = 1'b1;
					r_next.xfer_cnt = '0;
					r_next.phase = fsb_snoop_pkg::PH_DATA;
				end
			end
			fsb_snoop_pkg::PH_DATA:
			begin
				if (lif.word_valid)
				begin
					r_next.xfer_cnt = r_reg.xfer_cnt + `CNT_W'(1);
					if (r_next.xfer_cnt == `XFERS_PER_CLK)
						r_next.phase = fsb_snoop_pkg::PH_IDLE;
				end
			end
			default:
				r_next.phase = fsb_snoop_pkg::PH_IDLE;
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			r_reg <= '0;
			r_reg.trdy_n <= 1'b1; // pins idle high
			// bus clock idles low, so its stages stay clear: no false edge after reset
			r_reg.ads_s1 <= 1'b1;
			r_reg.ads_s2 <= 1'b1;
			r_reg.lock_s1 <= 1'b1;
			r_reg.lock_s2 <= 1'b1;
			r_reg.hint_s1 <= 1'b1;
			r_reg.hint_s2 <= 1'b1;
			r_reg.hit_s1 <= 1'b1;
			r_reg.hit_s2 <= 1'b1;
			r_reg.hitm_s1 <= 1'b1;
			r_reg.hitm_s2 <= 1'b1;
		end
		else if (ce)
			r_reg <= r_next;
	end

	// ****************************************
	// outputs, all from flops
	// ****************************************
	assign target_ready_n = r_reg.trdy_n;
	assign req_valid = r_reg.req_valid;
	assign req_type_a = r_reg.cmd_a;
	assign req_type_b = r_reg.cmd_b;
	assign req_is_write = r_reg.is_write;
	assign req_auto_precharge = r_reg.auto_pc;
	assign wr_word = lif.word;
	assign wr_word_valid = lif.word_valid;
	assign snoop_modified = r_reg.snoop_mod;
	assign snoop_stall = r_reg.snoop_stall;
	assign atomic_active = r_reg.atomic;
	assign io_dram_grant = r_reg.io_grant;
	assign io_dram_block = r_reg.io_block;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_HITM_OWNS_LINE: assert property ($rose(r_reg.snoop_mod) |-> r_reg.is_write)
		else $error("modified hit did not start a data intake");
	AST_STALL_HOLDS: assert property (
		r_reg.snoop_stall |-> r_reg.phase == fsb_snoop_pkg::PH_SNOOP)
		else $error("snoop stall outside snoop phase");
	AST_LOCK_STARTS_ATOMIC: assert property (
		ce && bus_rise && !r_reg.ads_s2 && !r_reg.lock_s2 |=> r_reg.atomic)
		else $error("locked strobe did not open atomic sequence");
	AST_LOCK_BLOCKS_IO: assert property (ce && !r_reg.lock_s2 |=> r_reg.io_block)
		else $error("io path not blocked under lock");
	AST_NO_GRANT_LOCKED: assert property (r_reg.io_grant |-> !r_reg.io_block)
		else $error("io grant while blocked");
	AST_AUTOPC_READS: assert property (
		r_reg.req_valid && r_reg.auto_pc |-> !r_reg.is_write && r_reg.hint_cap)
		else $error("auto-precharge on unhinted or write request");
	AST_SECOND_HALF: assert property (
		ce && bus_fall && r_reg.phase == fsb_snoop_pkg::PH_REQ_B |=>
		r_reg.cmd_b == ~$past(r_reg.cmd_s2) && r_reg.phase == fsb_snoop_pkg::PH_SNOOP)
		else $error("second request half not captured");
	AST_TRDY_WITH_ROOM: assert property (
		$fell(r_reg.trdy_n) |-> $past(wr_buf_ready) && r_reg.phase == fsb_snoop_pkg::PH_TRDY)
		else $error("target ready without buffer room");

endmodule // fsb_snoop_ctrl

// *** fsb_cpu_model.sv ***
// processor side of the front-side bus: request phases, snoop answers, data
// assumes the bench calls one task at a time; released GTL+ lines float high
`timescale 1ns/10ps

module fsb_cpu_model (
	// bus clock and request pins
	output logic bus_clk,
	output logic addr_strobe_n,
	output logic [4:0] request_command_n,
	output logic page_close_hint_n,
	output logic bus_lock_n,
	// snoop result pins
	output logic snoop_hit_n,
	output logic snoop_hit_modified_n,
	// data pins
	output logic [63:0] host_data_n,
	output logic [3:0] data_invert_n,
	output logic [3:0] data_strobe_pos_n,
	output logic [3:0] data_strobe_neg_n
);
	// ****************************************
	// idle levels: bus clock stands low between frames
	// ****************************************
	initial
	begin
		bus_clk = 1'b0;
		{addr_strobe_n, page_close_hint_n, bus_lock_n} = 3'h7;
		{snoop_hit_n, snoop_hit_modified_n} = 2'h3;
		request_command_n = 5'h1f;
		host_data_n = '1;
		data_invert_n = 4'hf;
		data_strobe_pos_n = 4'hf;
		data_strobe_neg_n = 4'hf;
	end

	task automatic request(input logic [4:0] a, b, input logic hint, lock, hit, hitm);
		#13 addr_strobe_n = 1'b0;
		request_command_n = ~a;
		page_close_hint_n = ~hint;
		// lock held as the level asked
		bus_lock_n = ~lock;
		#160 bus_clk = 1'b1;
		#120 request_command_n = ~b;
		#40 bus_clk = 1'b0;
		addr_strobe_n = 1'b1;
		snoop_hit_n = ~hit;
		snoop_hit_modified_n = ~hitm;
		#160 bus_clk = 1'b1;
		#80 {request_command_n, page_close_hint_n, snoop_hit_n, snoop_hit_modified_n} = 8'hff;
		#80 bus_clk = 1'b0;
		// a stalled snoop needs one more bus clock to resolve
		if (hit && hitm)
		begin
			#160 bus_clk = 1'b1;
			#160 bus_clk = 1'b0;
		end
	endtask

	// one bus clock inside the data frame
	task automatic pulse();
		#160 bus_clk = 1'b1;
		#160 bus_clk = 1'b0;
	endtask

	task automatic word(input logic [63:0] d, input logic [3:0] inv, input logic neg);
		for (int g = 0; g < 4; g++)
			host_data_n[16*g +: 16] = inv[g] ? d[16*g +: 16] : ~d[16*g +: 16];
		data_invert_n = ~inv;
		#160 if (neg) data_strobe_neg_n = 4'h0; else data_strobe_pos_n = 4'h0;
		#160 {data_strobe_pos_n, data_strobe_neg_n} = 8'hff;
		host_data_n = '1;
		data_invert_n = 4'hf;
	endtask
endmodule // fsb_cpu_model

// *** tb_fsb_snoop_ctrl.sv ***
// self-checking bench for the snoop, lock and request controller
// assumes fsb_cpu_model plays the processor and the bench the scheduler
`timescale 1ns/10ps

module tb_fsb_snoop_ctrl;
	logic ref_clk = 1'b0, srst = 1'b1, ce = 1'b1;
	logic req_ready = 1'b0, wr_buf_ready = 1'b0, io_dram_req = 1'b0;
	logic bus_clk, addr_strobe_n, page_close_hint_n, bus_lock_n;
	logic snoop_hit_n, snoop_hit_modified_n, target_ready_n, req_valid;
	logic req_is_write, req_auto_precharge, wr_word_valid, stall_seen;
	logic snoop_modified, snoop_stall, atomic_active, io_dram_grant, io_dram_block;
	logic [4:0] request_command_n, req_type_a, req_type_b;
	logic [63:0] host_data_n, wr_word;
	logic [3:0] data_invert_n, data_strobe_pos_n, data_strobe_neg_n;
	logic [63:0] words[$];
	int bad_count = 0, check_count = 0;

	fsb_snoop_ctrl fsb_snoop_ctrl_inst (.ref_clk, .srst, .ce, .bus_clk, .addr_strobe_n,
		.request_command_n, .page_close_hint_n, .bus_lock_n, .snoop_hit_n,
		.snoop_hit_modified_n, .host_data_n, .data_invert_n, .data_strobe_pos_n,
		.data_strobe_neg_n, .target_ready_n, .req_valid, .req_type_a, .req_type_b,
		.req_is_write, .req_auto_precharge, .req_ready, .wr_buf_ready, .wr_word,
		.wr_word_valid, .snoop_modified, .snoop_stall, .atomic_active, .io_dram_req,
		.io_dram_grant, .io_dram_block);

	fsb_cpu_model fsb_cpu_model_inst (.bus_clk, .addr_strobe_n, .request_command_n,
		.page_close_hint_n, .bus_lock_n, .snoop_hit_n, .snoop_hit_modified_n,
		.host_data_n, .data_invert_n, .data_strobe_pos_n, .data_strobe_neg_n);

	// ****************************************
	// clock and monitors
	// ****************************************
	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end

	// words are pulses, so they are queued just after the edge that launches them
	always @(posedge ref_clk)
	begin
		#1;
		if (wr_word_valid === 1'b1) words.push_back(wr_word);
		if (snoop_stall === 1'b1) stall_seen = 1'b1;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [63:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_lvl(ref logic s, input logic lvl);
		@(posedge ref_clk);
		#1;
		for (int i = 0; i < 400 && s !== lvl; i++)
		begin
			@(posedge ref_clk);
			#1;
		end
		if (s !== lvl)
		begin
			bad_count++;
			end_of_test();
		end
	endtask

	// scheduler takes the request after checking what it carries
	task automatic take(input logic [4:0] a, b, input logic wr);
		wait_lvl(req_valid, 1'b1);
		check(req_type_a, a);
		check(req_type_b, b);
		check(req_is_write, wr);
		req_ready = 1'b1;
		@(posedge ref_clk);
		#1 req_ready = 1'b0;
		@(posedge ref_clk);
		#1 check(req_valid, 1'b0);
	endtask

	task automatic wline();
		repeat (20) @(posedge ref_clk);
		#1 check(target_ready_n, 1'b1);
		wr_buf_ready = 1'b1;
		wait_lvl(target_ready_n, 1'b0);
		words.delete();
		fsb_cpu_model_inst.pulse();
		for (int k = 0; k < 4; k++)
			fsb_cpu_model_inst.word(64'h0123_4567_89ab_cdef + 64'(k), 4'(k * 5), k[0]);
		repeat (4) @(posedge ref_clk);
		#1 wr_buf_ready = 1'b0;
		check(target_ready_n, 1'b1);
		check(64'(words.size()), 64'h4);
		foreach (words[k]) check(words[k], 64'h0123_4567_89ab_cdef + 64'(k));
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_read_hint();
		fsb_cpu_model_inst.request(5'h04, 5'h0c, 1'b1, 1'b0, 1'b0, 1'b0);
		wait_lvl(req_valid, 1'b1);
		check(req_auto_precharge, 1'b1);
		// enable low freezes the request even with the scheduler ready
		ce = 1'b0;
		req_ready = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 check(req_valid, 1'b1);
		check(req_auto_precharge, 1'b1);
		ce = 1'b1;
		req_ready = 1'b0;
		take(5'h04, 5'h0c, 1'b0);
	endtask

	task automatic s_write();
		fsb_cpu_model_inst.request(5'h06, 5'h11, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_lvl(req_valid, 1'b1);
		check(req_auto_precharge, 1'b0);
		take(5'h06, 5'h11, 1'b1);
		wline();
	endtask

	task automatic s_hit_modified();
		fsb_cpu_model_inst.request(5'h08, 5'h01, 1'b0, 1'b0, 1'b0, 1'b1);
		wait_lvl(req_valid, 1'b1);
		check(snoop_modified, 1'b1);
		take(5'h08, 5'h01, 1'b1);
		wline();
	endtask

	task automatic s_stall();
		stall_seen = 1'b0;
		fsb_cpu_model_inst.request(5'h04, 5'h00, 1'b0, 1'b0, 1'b1, 1'b1);
		check(stall_seen, 1'b1);
		take(5'h04, 5'h00, 1'b0);
		check(snoop_modified, 1'b0);
	endtask

	task automatic s_lock();
		io_dram_req = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 check(io_dram_grant, 1'b1);
		for (int n = 0; n < 2; n++)
		begin
			fsb_cpu_model_inst.request(5'h04, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0);
			check(atomic_active, 1'b1);
			check(io_dram_block, 1'b1);
			check(io_dram_grant, 1'b0);
			take(5'h04, 5'h00, 1'b0);
		end
		fsb_cpu_model_inst.request(5'h04, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (6) @(posedge ref_clk);
		#1 check(atomic_active, 1'b0);
		check(io_dram_block, 1'b0);
		check(io_dram_grant, 1'b1);
		take(5'h04, 5'h00, 1'b0);
		io_dram_req = 1'b0;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge ref_clk);
		#1 srst = 1'b0;
		check(target_ready_n, 1'b1);
		check({req_valid, atomic_active, io_dram_block}, 3'h0);
		repeat (4) @(posedge ref_clk);
		s_read_hint();
		s_write();
		s_hit_modified();
		s_stall();
		s_lock();
		end_of_test();
	end
endmodule // tb_fsb_snoop_ctrl
